// ===== pkg/btm_consts.svh
`ifndef BTM_CONSTS_SVH
`define BTM_CONSTS_SVH

// Operation word patterns
`define BTM_GRP_HI          4'h0
`define BTM_DYN_INV_SEL     3'b101
`define BTM_DYN_CLR_SEL     3'b110
`define BTM_IMM_INV_PAT     10'b00_0010_0001
`define BTM_IMM_CLR_PAT     10'b00_0010_0010

// Operation word fields
`define BTM_HI_MSB          15
`define BTM_HI_LSB          12
`define BTM_DREG_MSB        11
`define BTM_DREG_LSB        9
`define BTM_SEL_MSB         8
`define BTM_SEL_LSB         6
`define BTM_MODE_MSB        5
`define BTM_MODE_LSB        3
`define BTM_REG_MSB         2
`define BTM_REG_LSB         0

// Destination modes
`define BTM_MODE_DREG       3'b000
`define BTM_MODE_AREG       3'b001
`define BTM_MODE_INDEX      3'b110
`define BTM_MODE_EXT        3'b111
`define BTM_EXT_ABS_W       3'b000
`define BTM_EXT_ABS_L       3'b001

// Index extension word fields
`define BTM_IDX_FULL_BIT    8
`define BTM_IDX_IIS_MSB     2
`define BTM_IDX_IIS_LSB     0

// Condition code positions, {X,N,Z,V,C}
`define BTM_CCR_Z           2

// Reset values
`define BTM_WORD_RST        16'h0000
`define BTM_LONG_RST        32'h0000_0000
`define BTM_BYTE_RST        8'h00
`define BTM_CCR_RST         5'h00

`endif

// ===== pkg/btm_pkg.sv
package btm_pkg;

    typedef enum logic [1:0] {
        BTM_OP_NONE,
        BTM_OP_INVERT,
        BTM_OP_CLEAR
    } btm_op_t;

    // Which family member the core behaves as
    typedef enum logic [1:0] {
        BTM_CORE_BASIC,
        BTM_CORE_LATER,
        BTM_CORE_REDUCED
    } btm_core_t;

    typedef enum logic [2:0] {
        BTM_ST_IDLE,
        BTM_ST_BITW,
        BTM_ST_RDN,
        BTM_ST_RDD,
        BTM_ST_IDXW,
        BTM_ST_MRD,
        BTM_ST_EXEC,
        BTM_ST_MWR
    } btm_state_t;

endpackage

// ===== verilog/btm_modify.sv
`timescale 1ns/1ps
`include "btm_consts.svh"

module btm_modify
    import btm_pkg::*;
(
    input  wire logic [31:0] operand,
    input  wire logic [31:0] bit_raw,
    input  wire logic        is_long,
    input  wire logic        is_clear,
    output logic             zero,
    output logic [31:0]      result
);
    logic [4:0]  bit_sel;
    logic [31:0] mask;

    always_comb begin
        bit_sel = is_long ? bit_raw[4:0] : {2'b00, bit_raw[2:0]};
        mask    = 32'h0000_0001 << bit_sel;
        zero    = ~|(operand & mask);
        if (is_clear) begin
            result = operand & ~mask;
        end else begin
            result = operand ^ mask;
        end
    end
endmodule

// ===== verilog/btm_top.sv
// How it works
// - Zero flag gets complement of tested bit; other flags pass unchanged.
// - Data register destination works on 32 bits, bit number modulo 32.
// - Memory destination works on one byte, bit number modulo 8.
// - Bit number zero is always the least significant bit.
// - Invert writes back destination with only the chosen bit flipped.
// - Clear writes back destination with only the chosen bit zeroed.
// - Immediate form fetches bit number from the following extension word.
// - Register form reads bit number from data register in bits 11..9.
// - Register invert: bits 15..12 zero, bits 8..6 equal 101.
// - Immediate invert: bits 15..6 0000100001; extension upper byte zero.
// - Only data alterable destination modes are accepted.
// - Address register, immediate and PC relative destinations are illegal.
// - Size is long for data register, byte for all other modes.
// - Mode 110 full forms on later cores; reduced core base-displacement only.
`timescale 1ns/1ps
`include "btm_consts.svh"

module btm_top
    import btm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire btm_core_t   core_kind,
    input  wire logic        op_valid,
    input  wire logic [15:0] op_word,
    output logic             op_ready,
    output logic             ext_req,
    input  wire logic        ext_valid,
    input  wire logic [15:0] ext_word,
    output logic [2:0]       dreg_rd_sel,
    input  wire logic [31:0] dreg_rd_data,
    output logic             dreg_wr_en,
    output logic [2:0]       dreg_wr_sel,
    output logic [31:0]      dreg_wr_data,
    output logic             mem_req,
    output logic             mem_we,
    output logic             mem_lock,
    output logic [2:0]       mem_ea_mode,
    output logic [2:0]       mem_ea_reg,
    output logic [15:0]      mem_idx_ext,
    output logic [7:0]       mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic [4:0]  ccr_in,
    output logic             ccr_we,
    output logic [4:0]       ccr_out,
    output logic             illegal,
    output logic             done
);
    // =========================================================
    // Decode helpers
    // =========================================================
    function automatic btm_op_t op_kind(input logic [15:0] w);
        btm_op_t k;
        k = BTM_OP_NONE;
        if (w[`BTM_HI_MSB:`BTM_HI_LSB] == `BTM_GRP_HI) begin
            if (w[`BTM_SEL_MSB:`BTM_SEL_LSB] == `BTM_DYN_INV_SEL) begin
                k = BTM_OP_INVERT;
            end else if (w[`BTM_SEL_MSB:`BTM_SEL_LSB] == `BTM_DYN_CLR_SEL) begin
                k = BTM_OP_CLEAR;
            end else if (w[15:6] == `BTM_IMM_INV_PAT) begin
                k = BTM_OP_INVERT;
            end else if (w[15:6] == `BTM_IMM_CLR_PAT) begin
                k = BTM_OP_CLEAR;
            end
        end
        return k;
    endfunction

    function automatic logic is_imm_form(input logic [15:0] w);
        return w[`BTM_SEL_MSB] == 1'b0;
    endfunction

    function automatic logic ea_ok(input logic [2:0] m, input logic [2:0] r);
        logic ok;
        ok = 1'b1;
        if (m == `BTM_MODE_AREG) begin
            ok = 1'b0;
        end else if (m == `BTM_MODE_EXT) begin
            ok = (r == `BTM_EXT_ABS_W) || (r == `BTM_EXT_ABS_L);
        end
        return ok;
    endfunction

    // =========================================================
    // State and captured instruction
    // =========================================================
    btm_state_t  state_reg;
    logic [15:0] word_reg;
    logic [31:0] bitnum_reg;
    logic [31:0] operand_reg;
    logic        is_long;
    logic        is_clear;
    logic        zero;
    logic [31:0] result;
    logic [2:0]  ea_mode;
    logic [2:0]  ea_reg;
    btm_op_t     new_kind;
    logic        idx_bad;

    assign ea_mode  = word_reg[`BTM_MODE_MSB:`BTM_MODE_LSB];
    assign ea_reg   = word_reg[`BTM_REG_MSB:`BTM_REG_LSB];
    assign is_long  = (ea_mode == `BTM_MODE_DREG);
    assign is_clear = (op_kind(word_reg) == BTM_OP_CLEAR);
    assign new_kind = op_kind(op_word);

    // Basic core knows only the brief index word; reduced core rejects memory indirect
    assign idx_bad  = ext_word[`BTM_IDX_FULL_BIT] &&
                      ((core_kind == BTM_CORE_BASIC) ||
                       ((core_kind == BTM_CORE_REDUCED) &&
                        (ext_word[`BTM_IDX_IIS_MSB:`BTM_IDX_IIS_LSB] != 3'b000)));

    btm_modify u_modify (
        .operand  (operand_reg),
        .bit_raw  (bitnum_reg),
        .is_long  (is_long),
        .is_clear (is_clear),
        .zero     (zero),
        .result   (result)
    );

    // =========================================================
    // Sequencer
    // =========================================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= BTM_ST_IDLE;
        end else begin
            case (state_reg)
                BTM_ST_IDLE: begin
                    if (op_valid && new_kind != BTM_OP_NONE &&
                        ea_ok(op_word[5:3], op_word[2:0])) begin
                        state_reg <= is_imm_form(op_word) ? BTM_ST_BITW
                                                          : BTM_ST_RDN;
                    end
                end
                BTM_ST_BITW, BTM_ST_RDN: begin
                    if (state_reg == BTM_ST_BITW && !ext_valid) begin
                        state_reg <= BTM_ST_BITW;
                    end else if (state_reg == BTM_ST_BITW && ext_word[15:8] != 8'h00) begin
                        state_reg <= BTM_ST_IDLE;
                    end else if (ea_mode == `BTM_MODE_DREG) begin
                        state_reg <= BTM_ST_RDD;
                    end else if (ea_mode == `BTM_MODE_INDEX) begin
                        state_reg <= BTM_ST_IDXW;
                    end else begin
                        state_reg <= BTM_ST_MRD;
                    end
                end
                BTM_ST_IDXW: begin
                    if (ext_valid) begin
                        state_reg <= idx_bad ? BTM_ST_IDLE : BTM_ST_MRD;
                    end
                end
                BTM_ST_RDD: state_reg <= BTM_ST_EXEC;
                BTM_ST_MRD: begin
                    if (mem_ack) begin
                        state_reg <= BTM_ST_EXEC;
                    end
                end
                BTM_ST_EXEC: state_reg <= is_long ? BTM_ST_IDLE : BTM_ST_MWR;
                BTM_ST_MWR: begin
                    if (mem_ack) begin
                        state_reg <= BTM_ST_IDLE;
                    end
                end
                default: state_reg <= BTM_ST_IDLE;
            endcase
        end
    end

    // =========================================================
    // Operand capture
    // =========================================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            word_reg    <= `BTM_WORD_RST;
            bitnum_reg  <= `BTM_LONG_RST;
            operand_reg <= `BTM_LONG_RST;
            mem_idx_ext <= `BTM_WORD_RST;
        end else begin
            if (state_reg == BTM_ST_IDLE && op_valid) begin
                word_reg <= op_word;
            end
            if (state_reg == BTM_ST_BITW && ext_valid) begin
                bitnum_reg <= {24'h00_0000, ext_word[7:0]};
            end
            if (state_reg == BTM_ST_RDN) begin
                bitnum_reg <= dreg_rd_data;
            end
            if (state_reg == BTM_ST_IDXW && ext_valid) begin
                mem_idx_ext <= ext_word;
            end
            if (state_reg == BTM_ST_RDD) begin
                operand_reg <= dreg_rd_data;
            end
            if (state_reg == BTM_ST_MRD && mem_ack) begin
                operand_reg <= {24'h00_0000, mem_rdata};
            end
        end
    end

    // =========================================================
    // Handshakes toward fetch, register file and memory
    // =========================================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op_ready    <= 1'b1;
            ext_req     <= 1'b0;
            dreg_rd_sel <= 3'b000;
            mem_req     <= 1'b0;
            mem_we      <= 1'b0;
            mem_lock    <= 1'b0;
            mem_ea_mode <= 3'b000;
            mem_ea_reg  <= 3'b000;
            mem_wdata   <= `BTM_BYTE_RST;
        end else begin
            case (state_reg)
                BTM_ST_IDLE: begin
                    if (op_valid && new_kind != BTM_OP_NONE &&
                        ea_ok(op_word[5:3], op_word[2:0])) begin
                        op_ready    <= 1'b0;
                        ext_req     <= is_imm_form(op_word);
                        dreg_rd_sel <= op_word[`BTM_DREG_MSB:`BTM_DREG_LSB];
                        mem_ea_mode <= op_word[5:3];
                        mem_ea_reg  <= op_word[2:0];
                    end
                end
                BTM_ST_BITW, BTM_ST_RDN: begin
                    if (state_reg == BTM_ST_RDN || ext_valid) begin
                        if (state_reg == BTM_ST_BITW && ext_word[15:8] != 8'h00) begin
                            ext_req  <= 1'b0;
                            op_ready <= 1'b1;
                        end else begin
                            ext_req     <= (ea_mode == `BTM_MODE_INDEX);
                            dreg_rd_sel <= ea_reg;
                            mem_req     <= !is_long && (ea_mode != `BTM_MODE_INDEX);
                            mem_lock    <= !is_long;
                        end
                    end
                end
                BTM_ST_IDXW: begin
                    if (ext_valid) begin
                        ext_req  <= 1'b0;
                        mem_req  <= !idx_bad;
                        mem_lock <= !idx_bad;
                        op_ready <= idx_bad;
                    end
                end
                BTM_ST_MRD: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                    end
                end
                BTM_ST_EXEC: begin
                    if (is_long) begin
                        op_ready <= 1'b1;
                    end else begin
                        mem_wdata <= result[7:0];
                        mem_req   <= 1'b1;
                        mem_we    <= 1'b1;
                    end
                end
                BTM_ST_MWR: begin
                    if (mem_ack) begin
                        mem_req  <= 1'b0;
                        mem_we   <= 1'b0;
                        mem_lock <= 1'b0;
                        op_ready <= 1'b1;
                    end
                end
                default: op_ready <= op_ready;
            endcase
        end
    end

    // =========================================================
    // Results, flags and completion pulses
    // =========================================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dreg_wr_en   <= 1'b0;
            dreg_wr_sel  <= 3'b000;
            dreg_wr_data <= `BTM_LONG_RST;
            ccr_we       <= 1'b0;
            ccr_out      <= `BTM_CCR_RST;
            illegal      <= 1'b0;
            done         <= 1'b0;
        end else begin
            dreg_wr_en <= 1'b0;
            ccr_we     <= 1'b0;
            illegal    <= 1'b0;
            done       <= 1'b0;
            if (state_reg == BTM_ST_IDLE && op_valid) begin
                illegal <= (new_kind == BTM_OP_NONE) ||
                           !ea_ok(op_word[5:3], op_word[2:0]);
            end
            if (state_reg == BTM_ST_BITW && ext_valid && ext_word[15:8] != 8'h00) begin
                illegal <= 1'b1;
            end
            if (state_reg == BTM_ST_IDXW && ext_valid && idx_bad) begin
                illegal <= 1'b1;
            end
            if (state_reg == BTM_ST_EXEC) begin
                // Flag leaves before or with the write, always from the old value
                ccr_we  <= 1'b1;
                ccr_out <= {ccr_in[4:3], zero, ccr_in[1:0]};
                if (is_long) begin
                    dreg_wr_en   <= 1'b1;
                    dreg_wr_sel  <= ea_reg;
                    dreg_wr_data <= result;
                    done         <= 1'b1;
                end
            end
            if (state_reg == BTM_ST_MWR && mem_ack) begin
                done <= 1'b1;
            end
        end
    end
endmodule

// ===== verification/btm_properties.sv
`timescale 1ns/1ps

module btm_checker (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        op_valid,
    input wire logic [15:0] op_word,
    input wire logic        op_ready,
    input wire logic        ext_req,
    input wire logic [2:0]  dreg_rd_sel,
    input wire logic        dreg_wr_en,
    input wire logic [2:0]  dreg_wr_sel,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic        mem_lock,
    input wire logic [2:0]  mem_ea_mode,
    input wire logic [2:0]  mem_ea_reg,
    input wire logic        mem_ack,
    input wire logic [4:0]  ccr_in,
    input wire logic        ccr_we,
    input wire logic [4:0]  ccr_out,
    input wire logic        illegal,
    input wire logic        done
);
    // ==========================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    other_flags_a: assert property (ccr_we |-> ccr_out[4:3] == $past(ccr_in[4:3])
        && ccr_out[1:0] == $past(ccr_in[1:0])) else $error("flags other than zero changed");
    flag_timing_a: assert property (ccr_we |-> done || (mem_req && mem_we))
        else $error("flag update out of place");
    dreg_flow_a: assert property (op_valid && op_ready && op_word[15:12] == 4'h0
        && (op_word[8:6] == 3'h5 || op_word[8:6] == 3'h6) && op_word[5:3] == 3'h0
        |=> dreg_rd_sel == $past(op_word[11:9]) ##1 dreg_rd_sel == $past(op_word[2:0], 2)
        ##2 done && dreg_wr_en && dreg_wr_sel == $past(op_word[2:0], 4))
        else $error("register form sequence wrong");
    areg_illegal_a: assert property (op_valid && op_ready && op_word[5:3] == 3'h1
        |=> illegal) else $error("address register destination accepted");
    pc_illegal_a: assert property (op_valid && op_ready && op_word[5:3] == 3'h7
        && op_word[2:1] != 2'h0 |=> illegal) else $error("pc or immediate destination accepted");
    imm_fetch_a: assert property (op_valid && op_ready && op_word[5:3] == 3'h2
        && (op_word[15:6] == 10'h021 || op_word[15:6] == 10'h022) |=> ext_req && !op_ready)
        else $error("immediate form did not ask for bit word");
    read_write_a: assert property (mem_req && !mem_we && mem_ack
        |=> !mem_req ##1 mem_req && mem_we && ccr_we) else $error("write does not follow read");
    write_done_a: assert property (mem_req && mem_we && mem_ack
        |=> done && op_ready && !mem_lock) else $error("write ack did not finish");
    lock_read_a: assert property ($rose(mem_req) && !mem_we |-> mem_lock)
        else $error("read without lock");
    same_place_a: assert property (mem_lock && $past(mem_lock)
        |-> $stable(mem_ea_mode) && $stable(mem_ea_reg)) else $error("destination moved");
endmodule

bind btm_top btm_checker chk_u (.*);

// ===== verification/btm_partner.sv
`timescale 1ns/1ps

module btm_partner (
    input  wire logic        clk,
    input  wire logic [3:0]  wait_cycles,
    input  wire logic [2:0]  dreg_rd_sel,
    output logic      [31:0] dreg_rd_data,
    input  wire logic        dreg_wr_en,
    input  wire logic [2:0]  dreg_wr_sel,
    input  wire logic [31:0] dreg_wr_data,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [2:0]  mem_ea_reg,
    input  wire logic [7:0]  mem_wdata,
    output logic             mem_ack,
    output logic      [7:0]  mem_rdata
);
    logic [31:0] regs [8];
    logic [7:0]  mem_q [8];
    logic [3:0]  cnt_q = 4'h0;

    initial mem_ack = 1'b0;
    initial mem_rdata = 8'h00;
    assign dreg_rd_data = regs[dreg_rd_sel];

    always @(posedge clk) begin
        if (dreg_wr_en)
            regs[dreg_wr_sel] <= dreg_wr_data;
        if (mem_req && mem_we && mem_ack)
            mem_q[mem_ea_reg] <= mem_wdata;
    end

    // Read data is only valid with ack; otherwise it toggles so stale values never match
    always @(negedge clk) begin
        if (mem_req && !mem_ack && cnt_q >= wait_cycles) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem_q[mem_ea_reg];
            cnt_q <= 4'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt_q <= mem_req ? cnt_q + 4'h1 : 4'h0;
        end
    end
endmodule

// ===== verification/bit_test_modify_unit_tb.sv
`timescale 1ns/1ps

module bit_test_modify_unit_tb;
    import btm_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, op_valid = 1'b0, ext_valid = 1'b0;
    btm_core_t   core_kind = BTM_CORE_LATER;
    logic [15:0] op_word = 16'h0000, ext_word = 16'h0000, mem_idx_ext, ix;
    logic [4:0]  ccr_in = 5'h1B, ccr_out, cc;
    logic [3:0]  wait_cycles = 4'h0;
    logic [2:0]  dreg_rd_sel, dreg_wr_sel, mem_ea_mode, mem_ea_reg;
    logic [31:0] dreg_rd_data, dreg_wr_data, wd;
    logic [7:0]  mem_wdata, mem_rdata;
    logic op_ready, ext_req, dreg_wr_en, mem_req, mem_we, mem_lock, mem_ack;
    logic ccr_we, illegal, done, dn, il;
    int num_errors = 0, checked = 0, cycles = 0;

    always #50 clk = ~clk;

    btm_top dut_u (.clk(clk), .arst_n(arst_n), .core_kind(core_kind), .op_valid(op_valid),
        .op_word(op_word), .op_ready(op_ready), .ext_req(ext_req), .ext_valid(ext_valid),
        .ext_word(ext_word), .dreg_rd_sel(dreg_rd_sel), .dreg_rd_data(dreg_rd_data),
        .dreg_wr_en(dreg_wr_en), .dreg_wr_sel(dreg_wr_sel), .dreg_wr_data(dreg_wr_data),
        .mem_req(mem_req), .mem_we(mem_we), .mem_lock(mem_lock), .mem_ea_mode(mem_ea_mode),
        .mem_ea_reg(mem_ea_reg), .mem_idx_ext(mem_idx_ext), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ccr_in(ccr_in), .ccr_we(ccr_we),
        .ccr_out(ccr_out), .illegal(illegal), .done(done));

    btm_partner partner_u (.clk(clk), .wait_cycles(wait_cycles), .dreg_rd_sel(dreg_rd_sel),
        .dreg_rd_data(dreg_rd_data), .dreg_wr_en(dreg_wr_en), .dreg_wr_sel(dreg_wr_sel),
        .dreg_wr_data(dreg_wr_data), .mem_req(mem_req), .mem_we(mem_we),
        .mem_ea_reg(mem_ea_reg), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    // ==========================================
    // Helpers
    task final_report();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One instruction: operation word, n extension words, then wait for done or illegal
    task automatic exec(input logic [15:0] op, input logic [15:0] e0, input logic [15:0] e1,
                        input int n);
        int k;
        int j;
        dn = 1'b0;
        il = 1'b0;
        cc = 'x;
        wd = 'x;
        ix = 'x;
        @(negedge clk);
        op_valid = 1'b1;
        op_word = op;
        @(negedge clk);
        op_valid = 1'b0;
        for (k = 0; k < n; k++) begin
            for (j = 0; j < 20 && !ext_req; j++)
                @(negedge clk);
            ext_valid = 1'b1;
            ext_word = (k == 0) ? e0 : e1;
            @(negedge clk);
        end
        // Valid held across back-to-back words, dropped once after the last
        ext_valid = 1'b0;
        for (k = 0; k < 40 && !dn && !il; k++) begin
            if (ccr_we)
                cc = ccr_out;
            if (dreg_wr_en)
                wd = dreg_wr_data;
            if (mem_req && mem_we)
                wd = {24'h00_0000, mem_wdata};
            if (mem_req)
                ix = mem_idx_ext;
            dn = done;
            il = illegal;
            if (!dn && !il)
                @(negedge clk);
        end
    endtask

    // ==========================================
    // Scenarios
    task automatic test_reg_form();
        partner_u.regs[1] = 32'h0000_0023;
        partner_u.regs[2] = 32'hFFFF_FFF0;
        exec(16'h0342, 16'h0000, 16'h0000, 0);
        check("inv_done", {31'h0, dn}, 32'h0000_0001);
        check("inv_flags", {27'h0, cc}, 32'h0000_001F);
        check("inv_data", wd, 32'hFFFF_FFF8);
        partner_u.regs[1] = 32'h0000_001F;
        exec(16'h0382, 16'h0000, 16'h0000, 0);
        check("clr_flags", {27'h0, cc}, 32'h0000_001B);
        check("clr_data", wd, 32'h7FFF_FFF8);
        $display("test reg_form done");
    endtask

    task automatic test_mem_form();
        partner_u.mem_q[3] = 8'h0F;
        partner_u.mem_q[1] = 8'hFE;
        wait_cycles = 4'h2;
        ccr_in = 5'h14;
        exec(16'h0853, 16'h000B, 16'h0000, 1);
        check("imm_flags", {27'h0, cc}, 32'h0000_0010);
        ccr_in = 5'h1B;
        check("imm_data", wd, 32'h0000_0007);
        check("imm_store", {24'h0, partner_u.mem_q[3]}, 32'h0000_0007);
        wait_cycles = 4'h0;
        exec(16'h08B9, 16'h0000, 16'h0000, 1);
        check("abs_flags", {27'h0, cc}, 32'h0000_001F);
        check("abs_data", wd, 32'h0000_00FE);
        check("abs_locator", {26'h0, mem_ea_mode, mem_ea_reg}, 32'h0000_0039);
        $display("test mem_form done");
    endtask

    task automatic test_illegal();
        logic [15:0] bad [4] = '{16'h0348, 16'h037A, 16'h037C, 16'h0AC0};
        foreach (bad[i]) begin
            exec(bad[i], 16'h0000, 16'h0000, 0);
            check("bad_mode", {30'h0, il, dn}, 32'h0000_0002);
        end
        exec(16'h0850, 16'h0103, 16'h0000, 1);
        check("bad_bitword", {30'h0, il, dn}, 32'h0000_0002);
        $display("test illegal done");
    endtask

    task automatic test_index();
        partner_u.mem_q[4] = 8'h00;
        core_kind = BTM_CORE_LATER;
        exec(16'h0874, 16'h0002, 16'h0101, 2);
        check("later_full", {27'h0, cc}, 32'h0000_001F);
        check("later_data", wd, 32'h0000_0004);
        check("later_index", {16'h0, ix}, 32'h0000_0101);
        core_kind = BTM_CORE_REDUCED;
        exec(16'h0874, 16'h0002, 16'h0101, 2);
        check("reduced_full", {31'h0, il}, 32'h0000_0001);
        core_kind = BTM_CORE_BASIC;
        exec(16'h0874, 16'h0002, 16'h0100, 2);
        check("basic_full", {31'h0, il}, 32'h0000_0001);
        exec(16'h0874, 16'h0002, 16'h0000, 2);
        check("basic_brief", wd, 32'h0000_0000);
        $display("test index done");
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            final_report();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        test_reg_form();
        test_mem_form();
        test_illegal();
        test_index();
        final_report();
    end
endmodule
